/* File: hw/cmb_host.sv */
// Host controller driving a core memory bank over its interlocked bus.
//
// Notes on behaviour
// - Address and cycle type stand 75 ns before the master strobe rises.
// - Strobe rises only after the previous reply strobe has been released.
// - Slave replies; host drops strobe; slave then releases its reply.
// - After a read-pause the next cycle must be a write to it.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module cmb_host (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Memory bus pins.
  output logic [17:0] bus_addr,
  output logic cyc_c0_n,
  output logic cyc_c1_n,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in,
  output logic master_strobe,
  input wire logic slave_reply_strobe
);
  import cmb_pkg::*;

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic rd_wait;
    logic hready;
    logic [31:0] hrdata;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [1:0] ctype;
    logic done;
    logic refused;
    logic pause_pending;
    logic [17:0] pause_addr;
    logic [15:0] rdata;
    cmb_seq_e seq;
    logic [17:0] pin_addr;
    logic [1:0] pin_ct;
    logic [15:0] pin_data;
    logic pin_oe;
    logic pin_strobe;
  } cmb_host_s;

  cmb_host_s st_r;
  cmb_host_s st_nxt;
  cmb_tmr_if tif ();
  logic go_take;

  cmb_timer u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .tif(tif)
  );

  // The timer is restarted in the cycle a command is accepted.
  assign tif.start = go_take;

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    logic wr_now;
    logic go_req;
    logic is_write;
    logic [1:0] new_ct;
    logic ok;
    logic done_set;
    logic refused_set;
    wr_now = st_r.ph_valid && st_r.ph_write && hready;
    go_req = wr_now && (st_r.ph_addr == OFS_CTRL) && hwdata[CTRL_GO_BIT];
    new_ct = hwdata[1:0];
    is_write = new_ct[1];
    ok = 1'b0;
    done_set = 1'b0;
    refused_set = 1'b0;
    st_nxt = st_r;
    st_nxt.hready = 1'b1;

    // Address phase capture; reads get one wait state so that a write
    // just before them is already visible.
    if (hready) begin
      st_nxt.ph_valid = hsel && htrans[1];
      st_nxt.ph_write = hwrite;
      st_nxt.ph_addr = haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        st_nxt.rd_wait = 1'b1;
        st_nxt.hready = 1'b0;
      end
    end
    if (st_r.rd_wait) begin
      st_nxt.rd_wait = 1'b0;
      st_nxt.hready = 1'b1;
      unique case (st_r.ph_addr)
        OFS_ADDR: st_nxt.hrdata = {14'h0000, st_r.addr};
        OFS_WDATA: st_nxt.hrdata = {16'h0000, st_r.wdata};
        OFS_CTRL: st_nxt.hrdata = {30'h0000_0000, st_r.ctype};
        OFS_STATUS: st_nxt.hrdata = {28'h000_0000, st_r.refused,
          st_r.pause_pending, st_r.done, (st_r.seq != CMB_IDLE)};
        OFS_RDATA: st_nxt.hrdata = {16'h0000, st_r.rdata};
        default: st_nxt.hrdata = 32'h0000_0000;
      endcase
    end

    // Register writes; the done and refused flags are write-one-to-clear.
    if (wr_now) begin
      unique case (st_r.ph_addr)
        OFS_ADDR: st_nxt.addr = hwdata[17:0];
        OFS_WDATA: st_nxt.wdata = hwdata[15:0];
        OFS_CTRL: st_nxt.ctype = new_ct;
        OFS_STATUS: begin
          if (hwdata[STAT_DONE_BIT]) begin
            st_nxt.done = 1'b0;
          end
          if (hwdata[STAT_REFUSED_BIT]) begin
            st_nxt.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // A paired read-pause admits only a write to the same byte address.
    if (go_req) begin
      ok = (st_r.seq == CMB_IDLE) && (!st_r.pause_pending ||
        (is_write && (st_r.addr == st_r.pause_addr)));
      refused_set = !ok;
    end

    // Bus sequencer.
    unique case (st_r.seq)
      CMB_IDLE: begin
        if (ok) begin
          // Lines go on the bus here and are then held
          st_nxt.seq = CMB_SETUP;
          st_nxt.pin_addr = st_r.addr;
          st_nxt.pin_ct = ~new_ct;
          st_nxt.pin_data = st_r.wdata;
          st_nxt.pin_oe = is_write;
        end
      end
      CMB_SETUP: begin
        // Wait out the setup time and any reply still held
        if (tif.expired && !slave_reply_strobe) begin
          st_nxt.seq = CMB_STROBE;
          st_nxt.pin_strobe = 1'b1;
        end
      end
      CMB_STROBE: begin
        if (slave_reply_strobe) begin
          // Take read data with the reply, then drop the strobe
          st_nxt.seq = CMB_RELEASE;
          st_nxt.pin_strobe = 1'b0;
          // The type line for bit 1 is high on reads.
          if (st_r.pin_ct[1]) begin
            st_nxt.rdata = data_in;
          end
        end
      end
      CMB_RELEASE: begin
        // Lines stay put until the slave lets its reply go
        if (!slave_reply_strobe) begin
          st_nxt.seq = CMB_IDLE;
          st_nxt.pin_oe = 1'b0;
          done_set = 1'b1;
          if (st_r.pin_ct == ~CT_READ_PAUSE) begin
            st_nxt.pause_pending = 1'b1;
            st_nxt.pause_addr = st_r.pin_addr;
          end else if (!st_r.pin_ct[1]) begin
            st_nxt.pause_pending = 1'b0;
          end
        end
      end
    endcase

    // Hardware sets win over a software clear in the same cycle.
    if (done_set) begin
      st_nxt.done = 1'b1;
    end
    if (refused_set) begin
      st_nxt.refused = 1'b1;
    end
  end

  assign go_take = st_r.seq == CMB_IDLE && st_nxt.seq == CMB_SETUP;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.hready <= 1'b1;
      st_r.addr <= ADDR_RST;
      st_r.wdata <= WDATA_RST;
      st_r.pin_ct <= 2'h3;
      st_r.seq <= CMB_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops; the response is always OKAY.
  // ----------------------------------------------------------------------
  assign hreadyout = st_r.hready;
  assign hrdata = st_r.hrdata;
  assign hresp = 1'b0;
  assign bus_addr = st_r.pin_addr;
  assign cyc_c0_n = st_r.pin_ct[0];
  assign cyc_c1_n = st_r.pin_ct[1];
  assign data_out = st_r.pin_data;
  assign data_oe = st_r.pin_oe;
  assign master_strobe = st_r.pin_strobe;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  // Counts cycles the address and type lines have stood still, strobe high or low.
  logic [3:0] stable_cnt_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stable_cnt_r <= 4'h0;
    end else if (st_nxt.pin_addr != st_r.pin_addr ||
                 st_nxt.pin_ct != st_r.pin_ct) begin
      stable_cnt_r <= 4'h0;
    end else if (stable_cnt_r != 4'hF) begin
      stable_cnt_r <= stable_cnt_r + 4'h1;
    end
  end

  property p_setup;
    @(posedge core_clk) disable iff (!resetn)
    $rose(master_strobe) |-> stable_cnt_r >= SETUP_CYC;
  endproperty
  a_setup: assert property (p_setup)
    else $error("Strobe rose before the address setup time.");

  property p_no_overlap;
    @(posedge core_clk) disable iff (!resetn)
    $rose(master_strobe) |-> $past(!slave_reply_strobe);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("Strobe rose while a reply was still held.");

  property p_drop_on_reply;
    @(posedge core_clk) disable iff (!resetn)
    master_strobe && slave_reply_strobe |=> !master_strobe &&
      $stable(bus_addr);
  endproperty
  a_drop_on_reply: assert property (p_drop_on_reply)
    else $error("Strobe not dropped the cycle after the reply.");

  property p_pause_pair;
    @(posedge core_clk) disable iff (!resetn)
    $rose(master_strobe) && st_r.pause_pending |->
      !cyc_c1_n && bus_addr == st_r.pause_addr;
  endproperty
  a_pause_pair: assert property (p_pause_pair)
    else $error("Cycle after a read-pause is not a write to it.");

  c_read: cover property (@(posedge core_clk) disable iff (!resetn)
    master_strobe && cyc_c1_n && slave_reply_strobe);
  c_write: cover property (@(posedge core_clk) disable iff (!resetn)
    master_strobe && !cyc_c1_n && slave_reply_strobe);
  c_pause_pair: cover property (@(posedge core_clk) disable iff (!resetn)
    $rose(master_strobe) && st_r.pause_pending);
  c_refused: cover property (@(posedge core_clk) disable iff (!resetn)
    $rose(st_r.refused));

endmodule

/* File: hw/cmb_pkg.sv */
// Package with the constants shared by the core memory bus host files.
package cmb_pkg;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 75;
  // Least setup time rounds up to whole cycles.
  localparam int SETUP_CYC_I = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETUP_CYC = 4'(SETUP_CYC_I);

  // ----------------------------------------------------------------------
  // Register byte offsets of the host command port.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int CTRL_GO_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PAUSE_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  localparam logic [17:0] ADDR_RST = 18'h0_0000;
  localparam logic [15:0] WDATA_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // Cycle type codes; the bus lines carry the inverse of each bit.
  // ----------------------------------------------------------------------
  localparam logic [1:0] CT_READ_RESTORE = 2'h0;
  localparam logic [1:0] CT_READ_PAUSE = 2'h1;
  localparam logic [1:0] CT_WORD_WRITE = 2'h2;
  localparam logic [1:0] CT_BYTE_WRITE = 2'h3;

  typedef enum logic [2:0] {
    CMB_IDLE,
    CMB_SETUP,
    CMB_STROBE,
    CMB_RELEASE
  } cmb_seq_e;

endpackage

/* File: hw/cmb_tmr_if.sv */
// Interface between the bus sequencer and its setup timer.
`timescale 1ns/1ps
interface cmb_tmr_if;
  logic start;
  logic expired;
  modport ctl (output start, input expired);
  modport tmr (input start, output expired);
endinterface

/* File: hw/cmb_timer.sv */
// Down counter that times the address setup before the master strobe.
`timescale 1ns/1ps
module cmb_timer (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Timer handshake.
  cmb_tmr_if.tmr tif
);
  import cmb_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
  } cmb_tmr_s;

  cmb_tmr_s st_r;
  cmb_tmr_s st_nxt;

  // Load on start, then count down to zero and hold there.
  always_comb begin
    st_nxt = st_r;
    if (tif.start) begin
      st_nxt.cnt = SETUP_CYC;
    end else if (st_r.cnt != 4'h0) begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Expiry reads the register only. The start comes from the sequencer's
  // next state, so feeding it back here would close a combinational loop.
  // The count is loaded at the start edge, so the sequencer never sees a
  // stale zero.
  assign tif.expired = st_r.cnt == 4'h0;

endmodule

/* File: bench/cmb_mem_model.sv */
// Behavioural core memory bank answering the host on the strobe bus.
`timescale 1ns/1ps
module cmb_mem_model (
  // Clock and answer pacing.
  input wire logic core_clk,
  input wire logic [3:0] dly,
  // Memory bus pins.
  input wire logic [17:0] bus_addr,
  input wire logic cyc_c0_n,
  input wire logic cyc_c1_n,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic master_strobe,
  output logic [15:0] data_in,
  output logic slave_reply_strobe
);
  // --------
  // Storage.
  // --------
  logic [15:0] mem [0:16383];
  logic pause_r = 1'b0;
  logic sel;
  realtime t_chg = 0.0;
  int viol = 0;
  int cyc = 0;
  logic [13:0] w;
  logic [1:0] ct;

  // Only words 0 to 16383 are fitted, so word 16K and up never answers.
  assign sel = bus_addr[17:15] == 3'h0;

  // Lines may only move while no cycle is in flight.
  always @(bus_addr or cyc_c0_n or cyc_c1_n) begin
    t_chg = $realtime;
    if (master_strobe || slave_reply_strobe) viol++;
  end

  // The strobe has to find settled lines and a released reply.
  always @(posedge master_strobe) begin
    if ($realtime - t_chg < 75.0 || slave_reply_strobe) viol++;
  end

  // One cycle per strobe; the reply holds until the strobe drops.
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    slave_reply_strobe = 1'b0;
    data_in = 16'ha5a5;
    forever begin
      @(posedge core_clk);
      if (master_strobe === 1'b1 && sel) begin
        cyc++;
        w = bus_addr[14:1];
        ct = {~cyc_c1_n, ~cyc_c0_n};
        // A paused word must be written before anything else is done.
        if (pause_r && !ct[1]) viol++;
        if (data_oe !== ct[1]) viol++;
        repeat (dly) @(posedge core_clk);
        case (ct)
          2'h0: data_in <= mem[w];
          2'h1: begin
            data_in <= mem[w];
            pause_r = 1'b1;
          end
          2'h2: mem[w] = data_out;
          default: begin
            if (bus_addr[0]) mem[w][15:8] = data_out[15:8];
            else mem[w][7:0] = data_out[7:0];
          end
        endcase
        if (ct[1]) pause_r = 1'b0;
        slave_reply_strobe <= 1'b1;
        for (int n = 0; n < 30 && master_strobe !== 1'b0; n++)
          @(posedge core_clk);
        if (master_strobe !== 1'b0) viol++;
        slave_reply_strobe <= 1'b0;
        // A released line must not keep showing the old word.
        data_in <= ~data_in;
      end
    end
  end
endmodule

/* File: bench/tb_cmb_host.sv */
// Self-checking bench for the core memory bus host.
`timescale 1ns/1ps
module tb_cmb_host;
  import cmb_pkg::*;
  // --------
  // Signals.
  // --------
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] dly = 4'h0;
  logic hreadyout, hresp, c0_n, c1_n, data_oe, strobe, reply;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [17:0] bus_addr;
  logic [15:0] data_out, data_in;
  logic [15:0] exp_mem [0:16383];
  int failures = 0;
  int comparisons = 0;

  cmb_host u_cmb_host (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .bus_addr(bus_addr), .cyc_c0_n(c0_n), .cyc_c1_n(c1_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .master_strobe(strobe), .slave_reply_strobe(reply)
  );
  cmb_mem_model u_cmb_mem_model (
    .core_clk(core_clk), .dly(dly), .bus_addr(bus_addr), .cyc_c0_n(c0_n),
    .cyc_c1_n(c1_n), .data_out(data_out), .data_oe(data_oe),
    .master_strobe(strobe), .data_in(data_in), .slave_reply_strobe(reply)
  );

  // Free-running 100 MHz clock.
  initial forever #5 core_clk = ~core_clk;

  // --------
  // Tasks.
  // --------
  // Compare and count.
  task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // One AHB single transfer; waits on hready, never on a fixed count.
  task automatic bus(input logic wr, logic [7:0] a, logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Issue a command and poll status until the host is idle.
  task automatic cmd(input logic [17:0] a, logic [15:0] d, logic [1:0] c);
    bus(1'b1, OFS_ADDR, {14'h0000, a});
    bus(1'b1, OFS_WDATA, {16'h0000, d});
    bus(1'b1, OFS_CTRL, {23'h00_0000, 1'b1, 6'h00, c});
    for (int n = 0; n < 40; n++) begin
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
  endtask

  // Word left in the bank after one cycle.
  function automatic logic [15:0] nxt(logic [15:0] o, d, logic [1:0] c,
                                      logic b);
    case (c)
      CT_WORD_WRITE: nxt = d;
      CT_BYTE_WRITE: nxt = b ? {d[15:8], o[7:0]} : {o[15:8], d[7:0]};
      default: nxt = o;
    endcase
  endfunction

  // Run a cycle, check status and read data, then clear the done and refused flags.
  task automatic op(input logic [17:0] a, logic [15:0] d, logic [1:0] c);
    logic [15:0] o;
    o = exp_mem[a[14:1]];
    cmd(a, d, c);
    chk("status", {29'h0, c == CT_READ_PAUSE, 2'h2}, rd & 32'hF);
    if (!c[1]) begin
      bus(1'b0, OFS_RDATA, 32'h0000_0000);
      chk("rdata", {16'h0000, o}, rd);
    end
    exp_mem[a[14:1]] = nxt(o, d, c, a[0]);
    bus(1'b1, OFS_STATUS, 32'h0000_000A);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // --------
  // Tests.
  // --------
  // Guard against a hung handshake; the run needs far fewer cycles.
  initial begin
    #500_000;
    failures++;
    wrap_up();
  end

  // Register checks, then random cycles with pause pairs among them.
  initial begin
    logic [13:0] w;
    logic [17:0] a;
    logic [15:0] d;
    logic [1:0] c;
    int n;
    void'($urandom(32'h1193_3038));
    foreach (exp_mem[i]) exp_mem[i] = 16'h0000;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk("pins", 32'h0000_0003, {strobe, data_oe, c1_n, c0_n});
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status reset", 32'h0000_0000, rd);
    bus(1'b1, OFS_ADDR, 32'hFFFF_FFFF);
    bus(1'b0, OFS_ADDR, 32'h0000_0000);
    chk("addr", 32'h0003_FFFF, rd);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    $display("test registers done");
    for (int i = 0; i < 40; i++) begin
      w = 14'($urandom_range(0, 7));
      if ($urandom_range(0, 1) == 1) w = ~w;
      a = {3'h0, w, 1'($urandom_range(0, 1))};
      d = 16'($urandom);
      c = (i < 4) ? 2'(i) : 2'($urandom_range(0, 3));
      dly <= 4'($urandom_range(0, 6));
      op(a, d, c);
      if (c == CT_READ_PAUSE) begin
        n = u_cmb_mem_model.cyc;
        cmd(a ^ 18'h0_0002, d, CT_READ_RESTORE);
        chk("refused", 32'h0000_000C, rd & 32'hF);
        chk("cycles", n, u_cmb_mem_model.cyc);
        bus(1'b1, OFS_STATUS, 32'h0000_000A);
        op(a, ~d, i[0] ? CT_BYTE_WRITE : CT_WORD_WRITE);
      end
    end
    $display("test random cycles done");
    chk("protocol", 32'h0, u_cmb_mem_model.viol);
    $display("test protocol done");
    wrap_up();
  end
endmodule
